/* design/dac_ctrl_pkg.sv */
// Constants and types shared by the serial control port files
package dac_ctrl_pkg;

  localparam int unsigned WORD_BITS  = 16;
  localparam int unsigned ADDR_MSB   = 15;
  localparam int unsigned ADDR_LSB   = 12;
  localparam int unsigned DATA_BITS  = 10;
  localparam int unsigned RSVD_HI    = 11;
  localparam int unsigned RSVD_LO    = 10;
  localparam int unsigned NUM_VOL    = 6;

  // Register select codes
  localparam logic [3:0] ADDR_CFG1     = 4'h0;
  localparam logic [3:0] ADDR_CFG2     = 4'h1;
  localparam logic [3:0] ADDR_VOL_BASE = 4'h2;
  localparam logic [3:0] ADDR_CFG3     = 4'h8;

  // Field positions in the first control register
  localparam int unsigned DEEMPH_MSB = 9;
  localparam int unsigned DEEMPH_LSB = 8;
  localparam int unsigned FMT_MSB    = 7;
  localparam int unsigned FMT_LSB    = 5;
  localparam int unsigned WLEN_MSB   = 4;
  localparam int unsigned WLEN_LSB   = 3;
  localparam int unsigned SLEEP_BIT  = 2;
  localparam int unsigned INTERP_MSB = 1;
  localparam int unsigned INTERP_LSB = 0;

  // Field positions in the second and third control registers
  localparam int unsigned MUTE_MSB   = 5;
  localparam int unsigned MUTE_LSB   = 0;
  localparam int unsigned REPL_BIT   = 5;
  localparam int unsigned MCLK_MSB   = 4;
  localparam int unsigned MCLK_LSB   = 3;
  localparam int unsigned ZPOL_BIT   = 2;

  // Reset values
  localparam logic [9:0] CFG1_RESET = 10'h000;
  localparam logic [9:0] CFG2_RESET = 10'h000;
  localparam logic [9:0] CFG3_RESET = 10'h000;
  localparam logic [9:0] VOL_RESET  = 10'h3ff;

  typedef enum logic [1:0] {
    DEEMPH_OFF = 2'h0,
    DEEMPH_441 = 2'h1,
    DEEMPH_32  = 2'h2,
    DEEMPH_48  = 2'h3
  } deemph_e;

  typedef enum logic [2:0] {
    FMT_I2S      = 3'h0,
    FMT_RIGHT    = 3'h1,
    FMT_DSP      = 3'h2,
    FMT_LEFT     = 3'h3,
    FMT_PACK256  = 3'h4,
    FMT_PACK128  = 3'h5,
    FMT_AUX      = 3'h6,
    FMT_RESERVED = 3'h7
  } serial_fmt_e;

  typedef enum logic [1:0] {
    WLEN_24  = 2'h0,
    WLEN_20  = 2'h1,
    WLEN_16  = 2'h2,
    WLEN_RSV = 2'h3
  } word_len_e;

  typedef enum logic [1:0] {
    INTERP_8X  = 2'h0,
    INTERP_2X  = 2'h1,
    INTERP_4X  = 2'h2,
    INTERP_RSV = 2'h3
  } interp_e;

endpackage : dac_ctrl_pkg

/* design/ctrl_word_if.sv */
// Carrier of the shifted control word from link domain to core
`timescale 1ns/10ps
`default_nettype none
interface ctrl_word_if;
  logic [15:0] word;
  modport link (output word);
  modport core (input word);
endinterface : ctrl_word_if
`default_nettype wire

/* design/ctrl_shift_rx.sv */
// Shift register clocked by the control shift clock
`timescale 1ns/10ps
`default_nettype none
module ctrl_shift_rx (
  input  wire logic   ctrl_shift_clock,
  input  wire logic   ctrl_serial_in,
  ctrl_word_if.link   word_bus
);
  import dac_ctrl_pkg::*;

  typedef struct packed {
    logic [WORD_BITS-1:0] shift;
  } rx_state_s;

  rx_state_s rx_q;
  rx_state_s rx_d;

  // Shift clock stops between words, so no reset here; the
  // core only reads the word after the latch rises.
  always_comb begin
    rx_d       = rx_q;
    rx_d.shift = {rx_q.shift[WORD_BITS-2:0], ctrl_serial_in};
  end

  always_ff @(posedge ctrl_shift_clock) begin
    rx_q <= rx_d;
  end

  assign word_bus.word = rx_q.shift;

endmodule : ctrl_shift_rx
`default_nettype wire

/* design/dac_ctrl_port.sv */
// Write-only serial control port with register file and decode
//
// Notes on behaviour
// - Words are sixteen bits, MSB first
// - Top four bits select the register
// - Low ten bits go to that register
// - Data sampled on shift clock rising edge
// - Latch rising edge commits the shifted word
// - Nine registers: six volumes, three controls
// - Bits nine-eight choose de-emphasis curve
// - Bits seven-five choose serial format
// - Bits four-three choose input word length
// - Bit two puts converter to sleep
// - Bits one-zero choose interpolation ratio
// - Sleep bit applies on following latch edge
`timescale 1ns/10ps
`default_nettype none
module dac_ctrl_port (
  input  wire logic                           clk_sys,
  input  wire logic                           srst,
  input  wire logic                           ctrl_shift_clock,
  input  wire logic                           ctrl_serial_in,
  input  wire logic                           ctrl_word_latch,
  output logic [dac_ctrl_pkg::NUM_VOL-1:0][9:0] vol_level,
  output logic [dac_ctrl_pkg::NUM_VOL-1:0]      mute_mask,
  output logic                                stereo_replicate,
  output logic [1:0]                          mclk_ratio,
  output logic                                zero_flag_low,
  output dac_ctrl_pkg::deemph_e               deemph_mode,
  output dac_ctrl_pkg::serial_fmt_e           serial_format,
  output logic                                right_aligned_format,
  output logic                                left_aligned_format,
  output dac_ctrl_pkg::word_len_e             word_length,
  output logic                                sleep_setting,
  output dac_ctrl_pkg::interp_e               interp_ratio,
  output logic                                word_written,
  output logic                                reserved_addr_hit,
  output logic                                bad_code_written
);
  import dac_ctrl_pkg::*;

  ctrl_word_if word_bus ();

  ctrl_shift_rx u_rx (
    .ctrl_shift_clock (ctrl_shift_clock),
    .ctrl_serial_in   (ctrl_serial_in),
    .word_bus         (word_bus.link)
  );

  typedef struct packed {
    logic [1:0]                   latch_sync;
    logic                         latch_prev;
    logic [WORD_BITS-1:0]         word_meta;
    logic [WORD_BITS-1:0]         word_sync;
    logic [NUM_VOL-1:0][9:0]      vol;
    logic [DATA_BITS-1:0]         cfg1;
    logic [DATA_BITS-1:0]         cfg2;
    logic [DATA_BITS-1:0]         cfg3;
    logic                         sleep_pend;
    logic                         sleep_now;
    logic                         wr_pulse;
    logic                         rsvd_pulse;
    logic                         bad_pulse;
  } core_state_s;

  localparam core_state_s CORE_RESET = '{
    latch_sync: 2'h0,
    latch_prev: 1'b0,
    word_meta:  16'h0000,
    word_sync:  16'h0000,
    vol:        {NUM_VOL{VOL_RESET}},
    cfg1:       CFG1_RESET,
    cfg2:       CFG2_RESET,
    cfg3:       CFG3_RESET,
    sleep_pend: CFG1_RESET[SLEEP_BIT],
    sleep_now:  CFG1_RESET[SLEEP_BIT],
    wr_pulse:   1'b0,
    rsvd_pulse: 1'b0,
    bad_pulse:  1'b0
  };

  // Volume slot for an address, or all ones when not a volume
  function automatic logic [3:0] vol_slot(input logic [3:0] addr);
    logic [3:0] off;
    off = addr - ADDR_VOL_BASE;
    if (addr >= ADDR_VOL_BASE && off < 4'(NUM_VOL)) begin
      vol_slot = off;
    end else begin
      vol_slot = 4'hf;
    end
  endfunction : vol_slot

  // Reserved codes in the first control register fields
  function automatic logic cfg1_bad(input logic [DATA_BITS-1:0] v);
    cfg1_bad = (v[FMT_MSB:FMT_LSB] == FMT_RESERVED)
            || (v[WLEN_MSB:WLEN_LSB] == WLEN_RSV)
            || (v[INTERP_MSB:INTERP_LSB] == INTERP_RSV);
  endfunction : cfg1_bad

  core_state_s core_q;
  core_state_s core_d;

  logic [3:0]           wr_addr;
  logic [DATA_BITS-1:0] wr_data;
  logic [3:0]           slot;
  logic                 latch_rise;

  always_comb begin
    wr_addr    = core_q.word_sync[ADDR_MSB:ADDR_LSB];
    wr_data    = core_q.word_sync[DATA_BITS-1:0];
    slot       = vol_slot(wr_addr);
    latch_rise = core_q.latch_sync[1] & ~core_q.latch_prev;

    core_d            = core_q;
    core_d.latch_sync = {core_q.latch_sync[0], ctrl_word_latch};
    core_d.latch_prev = core_q.latch_sync[1];
    // Word settled long before the latch rises; two stages suffice
    core_d.word_meta  = word_bus.word;
    core_d.word_sync  = core_q.word_meta;
    core_d.wr_pulse   = 1'b0;
    core_d.rsvd_pulse = 1'b0;
    core_d.bad_pulse  = 1'b0;

    if (latch_rise) begin
      core_d.wr_pulse  = 1'b1;
      // Previously staged sleep bit takes effect now
      core_d.sleep_now = core_q.sleep_pend;
      if (wr_addr == ADDR_CFG1) begin
        core_d.cfg1       = wr_data;
        core_d.sleep_pend = wr_data[SLEEP_BIT];
        core_d.bad_pulse  = cfg1_bad(wr_data);
      end else if (wr_addr == ADDR_CFG2) begin
        core_d.cfg2 = wr_data;
      end else if (wr_addr == ADDR_CFG3) begin
        core_d.cfg3 = wr_data;
      end else if (slot != 4'hf) begin
        core_d.vol[slot[2:0]] = wr_data;
      end else begin
        core_d.rsvd_pulse = 1'b1;
      end
      // Reserved bits set by the host are flagged, data still taken
      if (core_q.word_sync[RSVD_HI] | core_q.word_sync[RSVD_LO]) begin
        core_d.bad_pulse = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      core_q <= CORE_RESET;
    end else begin
      core_q <= core_d;
    end
  end

  assign vol_level            = core_q.vol;
  assign mute_mask            = core_q.cfg2[MUTE_MSB:MUTE_LSB];
  assign stereo_replicate     = core_q.cfg3[REPL_BIT];
  assign mclk_ratio           = core_q.cfg3[MCLK_MSB:MCLK_LSB];
  assign zero_flag_low        = core_q.cfg3[ZPOL_BIT];
  assign deemph_mode          = deemph_e'(core_q.cfg1[DEEMPH_MSB:DEEMPH_LSB]);
  assign serial_format        = serial_fmt_e'(core_q.cfg1[FMT_MSB:FMT_LSB]);
  assign right_aligned_format = (serial_format == FMT_RIGHT);
  assign left_aligned_format  = (serial_format == FMT_LEFT);
  assign word_length          = word_len_e'(core_q.cfg1[WLEN_MSB:WLEN_LSB]);
  assign sleep_setting        = core_q.sleep_now;
  assign interp_ratio         = interp_e'(core_q.cfg1[INTERP_MSB:INTERP_LSB]);
  assign word_written         = core_q.wr_pulse;
  assign reserved_addr_hit    = core_q.rsvd_pulse;
  assign bad_code_written     = core_q.bad_pulse;

endmodule : dac_ctrl_port
`default_nettype wire

/* sim/dac_ctrl_port_monitor.sv */
// Concurrent checks on the control port outputs
`timescale 1ns/10ps
`default_nettype none
module dac_ctrl_port_monitor (
  input wire logic                              clk_sys,
  input wire logic                              srst,
  input wire logic                              ctrl_word_latch,
  input wire logic [dac_ctrl_pkg::NUM_VOL-1:0][9:0] vol_level,
  input wire logic [dac_ctrl_pkg::NUM_VOL-1:0]  mute_mask,
  input wire dac_ctrl_pkg::serial_fmt_e         serial_format,
  input wire logic                              right_aligned_format,
  input wire logic                              left_aligned_format,
  input wire logic                              sleep_setting,
  input wire logic                              word_written,
  input wire logic                              reserved_addr_hit
);
  import dac_ctrl_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence latch_rise; $rose(ctrl_word_latch); endsequence
  sequence commit_seen; ##[1:5] word_written; endsequence
  a_commit_follows: assert property (latch_rise |-> commit_seen)
    else $error("no commit after latch rise");
  a_write_single: assert property (word_written |=> !word_written)
    else $error("write pulse too long");
  a_write_latched: assert property (
    word_written |-> $past(ctrl_word_latch, 2))
    else $error("write without latch");
  a_rsv_no_change: assert property (
    reserved_addr_hit |-> $stable(vol_level) && $stable(mute_mask))
    else $error("reserved address changed a register");
  a_rsv_is_write: assert property (reserved_addr_hit |-> word_written)
    else $error("reserved flag outside a commit");
  a_regs_hold: assert property (
    !word_written |-> $stable(vol_level) && $stable(serial_format))
    else $error("register changed without commit");
  a_align_flags: assert property (
    right_aligned_format == (serial_format == FMT_RIGHT) &&
    left_aligned_format == (serial_format == FMT_LEFT))
    else $error("alignment flag wrong");
  a_sleep_on_latch: assert property (
    $changed(sleep_setting) |-> word_written)
    else $error("sleep changed without latch");
endmodule : dac_ctrl_port_monitor
bind dac_ctrl_port dac_ctrl_port_monitor u_mon (.clk_sys, .srst,
  .ctrl_word_latch, .vol_level, .mute_mask, .serial_format,
  .right_aligned_format, .left_aligned_format, .sleep_setting,
  .word_written, .reserved_addr_hit);
`default_nettype wire

/* sim/ctrl_host_model.sv */
// Host side of the serial control link
`timescale 1ns/10ps
`default_nettype none
module ctrl_host_model (
  output var logic ctrl_shift_clock,
  output var logic ctrl_serial_in,
  output var logic ctrl_word_latch
);
  initial begin
    ctrl_shift_clock = 1'b0;
    ctrl_serial_in = 1'b0;
    ctrl_word_latch = 1'b0;
  end
  // Clock idles low outside frames
  task automatic shift(input logic [15:0] w);
    #1.3;
    for (int i = 15; i >= 0; i--) begin
      ctrl_serial_in = w[i];
      #7.5 ctrl_shift_clock = 1'b1;
      #7.5 ctrl_shift_clock = 1'b0;
    end
    ctrl_serial_in = ~ctrl_serial_in;
  endtask : shift
  task automatic pulse();
    #12 ctrl_word_latch = 1'b1;
    #24 ctrl_word_latch = 1'b0;
    #24;
  endtask : pulse
endmodule : ctrl_host_model
`default_nettype wire

/* sim/audio_dac_serial_control_port_tb_top.sv */
// Self-checking bench for the serial control port
`timescale 1ns/10ps
`default_nettype none
module audio_dac_serial_control_port_tb_top;
  import dac_ctrl_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  wire logic ctrl_shift_clock, ctrl_serial_in, ctrl_word_latch;
  logic [NUM_VOL-1:0][9:0] vol_level;
  logic [NUM_VOL-1:0] mute_mask;
  logic [1:0] mclk_ratio;
  logic stereo_replicate, zero_flag_low, right_aligned_format;
  logic left_aligned_format, sleep_setting, word_written;
  logic reserved_addr_hit, bad_code_written;
  deemph_e deemph_mode;
  serial_fmt_e serial_format;
  word_len_e word_length;
  interp_e interp_ratio;
  logic [15:0] w, e;
  int checks = 0, bad_count = 0, n_sent = 0, wr_cnt = 0, rsv_cnt = 0;
  int code_cnt = 0;
  // Word to send, then expected view of the target register
  logic [31:0] rows [12] = '{32'h0129_0495, 32'h0252_012a, 32'h0360_03b0,
    32'h008a_0046, 32'h01b1_00d9, 32'h02c0_0160, 32'h0000_0000,
    32'h102a_002a, 32'h8034_000d, 32'h2155_0155, 32'h4001_0001,
    32'h7200_0200};
  dac_ctrl_port dut (.clk_sys, .srst, .ctrl_shift_clock, .ctrl_serial_in,
    .ctrl_word_latch, .vol_level, .mute_mask, .stereo_replicate,
    .mclk_ratio, .zero_flag_low, .deemph_mode, .serial_format,
    .right_aligned_format, .left_aligned_format, .word_length,
    .sleep_setting, .interp_ratio, .word_written, .reserved_addr_hit,
    .bad_code_written);
  ctrl_host_model host (.ctrl_shift_clock, .ctrl_serial_in,
    .ctrl_word_latch);
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (word_written === 1'b1) wr_cnt++;
    if (reserved_addr_hit === 1'b1) rsv_cnt++;
    if (bad_code_written !== 1'b0) code_cnt++;
  end
  function automatic logic [15:0] obs(input logic [3:0] a);
    case (a)
      4'h0: obs = {5'h0, right_aligned_format, left_aligned_format,
                   deemph_mode, serial_format, word_length, interp_ratio};
      4'h1: obs = {10'h0, mute_mask};
      4'h8: obs = {12'h0, stereo_replicate, mclk_ratio, zero_flag_low};
      default: obs = {6'h0, vol_level[a - 4'h2]};
    endcase
  endfunction : obs
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic send(input logic [15:0] word);
    host.shift(word);
    host.pulse();
    n_sent++;
  endtask : send
  task automatic summarize();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  initial begin
    #50000;
    bad_count++;
    summarize();
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    chk(vol_level, {6{10'h3ff}});
    chk({mute_mask, stereo_replicate, mclk_ratio, zero_flag_low,
         deemph_mode, serial_format, word_length, sleep_setting,
         interp_ratio}, '0);
    foreach (rows[i]) begin
      {w, e} = rows[i];
      send(w);
      chk(obs(w[15:12]), e);
    end
    send(16'h0004);
    chk(sleep_setting, 1'b0);
    send(16'h2155);
    chk(sleep_setting, 1'b1);
    send(16'h0000);
    chk(sleep_setting, 1'b1);
    send(16'h0000);
    chk(sleep_setting, 1'b0);
    for (int a = 9; a < 16; a++) send({a[3:0], 12'h000});
    chk(vol_level, {10'h200, 10'h3ff, 10'h3ff, 10'h001, 10'h3ff,
                    10'h155});
    chk(mute_mask, 6'h2a);
    chk(rsv_cnt, 7);
    host.shift(16'hffff);
    send(16'h32bc);
    chk(vol_level[1], 10'h2bc);
    chk(wr_cnt, n_sent);
    chk(code_cnt, 0);
    summarize();
  end
endmodule : audio_dac_serial_control_port_tb_top
`default_nettype wire
